// ---- pkg/mbs_defines.svh ----
// Purpose: Offsets, field positions and reset values of the bank switch and map block
// Assumes: Byte-wide registers on a plain address/strobe port
// Notes:   Definitions only
`ifndef MBS_DEFINES_SVH
`define MBS_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MBS_OFS_CFG0C 8'h0c
`define MBS_OFS_CFG0D 8'h0d
`define MBS_OFS_BSW_BASE 8'h20
`define MBS_OFS_BSEL_BASE 8'h30
`define MBS_OFS_MAP_BASE 8'h40
`define MBS_OFS_STATUS 8'h70
`define MBS_OFS_BSWLO_BASE 8'h80

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MBS_CFG0C_BSW_EN 0
`define MBS_CFG0C_GFX_EN 1
`define MBS_CFG0D_LARGE 0
`define MBS_CFG0D_ROW_HI 1
`define MBS_MAP_BSEL_LO 0
`define MBS_MAP_BSEL_HI 1
`define MBS_MAP_SHIFT_LO 2
`define MBS_MAP_SHIFT_HI 7
`define MBS_BSEL_CYC_LO 0
`define MBS_BSEL_CYC_HI 1
`define MBS_BSEL_WIDE 2
`define MBS_BSEL_MUX_LO 3
`define MBS_BSEL_MUX_HI 4
`define MBS_BSEL_ROM 5
`define MBS_BSEL_BANK_LO 6
`define MBS_BSEL_BANK_HI 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MBS_RST_CFG 8'h00
`define MBS_RST_BSW 12'h000
`define MBS_RST_MAP 8'h00
`define MBS_RST_BSEL 8'hc0

// ----------------------------------------
// Address constants
// ----------------------------------------
`define MBS_GFX_SEG 9'h017
`define MBS_NUM_MAP 34
`define MBS_NUM_BSW 9
`define MBS_NUM_BSEL 5

`endif

// ---- pkg/mbs_pkg.sv ----
// Purpose: Types of the bank switch and map block
// Assumes: Used together with mbs_defines.svh
// Notes:   Types only
package mbs_pkg;
   typedef enum logic [1:0] {
      MBS_CYC_DRAM = 2'h0,
      MBS_CYC_SRAM = 2'h1,
      MBS_CYC_XT = 2'h3,
      MBS_CYC_PCMCIA = 2'h2
   } mbs_cycle_t;
   typedef logic [11:0] mbs_bsw_t;
   typedef logic [7:0] mbs_byte_t;
endpackage

// ---- tb/mbs_cpu_bfm.sv ----
// Purpose: CPU address bus model in front of the bank switch and map block
// Assumes: One request cycle per start pulse
// Notes:   Between requests the bus inverts its address every cycle
`timescale 1ns/10ps
`default_nettype none
module mbs_cpu_bfm (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [23:0] addr,
   output logic [23:0] cpu_addr,
   output logic cpu_req
);
   // A released bus never keeps its last value, so stale decode cannot pass unnoticed
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cpu_req <= 1'b0;
         cpu_addr <= 24'h000000;
      end else begin
         cpu_req <= start;
         cpu_addr <= start ? addr : ~cpu_addr;
      end
   end
endmodule // mbs_cpu_bfm
`default_nettype wire

// ---- tb/mbs_map_asserts.sv ----
// Purpose: Port checks of the bank switch and map block
// Assumes: Sees the ports of mbs_map_top only
// Notes:   Row polarity is hidden, so the idle level is taken from the rows themselves
`timescale 1ns/10ps
`default_nettype none
module mbs_map_asserts #(
   parameter int NUM_MAP = 34,
   parameter int NUM_BSW = 9,
   parameter int NUM_BSEL = 5
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [23:0] cpu_addr,
   input wire logic cpu_req,
   input wire logic [25:0] phys_addr,
   input wire logic mem_valid,
   input wire logic bank0_select,
   input wire logic bank1_select,
   input wire logic bank2_select,
   input wire logic [1:0] bank_number,
   input wire logic rom_chip_select,
   input wire logic graphics_cycle
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic idle;
   assign idle = (bank0_select == bank1_select) && (bank1_select == bank2_select);
   a_low_bits_kept: assert property (cpu_req |=>
      mem_valid && phys_addr[13:0] == $past(cpu_addr[13:0]))
      else $error("low address bits altered");
   a_outside_window: assert property (cpu_req && cpu_addr[19:16] < 4'hb |=>
      phys_addr[16:0] == $past(cpu_addr[16:0]))
      else $error("address below window altered");
   a_high_no_shift: assert property (cpu_req && cpu_addr[23:22] != 2'h0 |=>
      phys_addr == {2'h0, $past(cpu_addr)})
      else $error("out of range access shifted");
   a_rows_idle: assert property (!mem_valid |-> idle)
      else $error("row select outside an access");
   a_ext_bank_idle: assert property (mem_valid && bank_number == 2'h3 |-> idle)
      else $error("row select for external bank");
   a_bank0_row: assert property (mem_valid && bank_number == 2'h0 && !graphics_cycle |->
      bank0_select != bank1_select && bank1_select == bank2_select)
      else $error("bank 0 row select wrong");
   a_bank2_row: assert property (mem_valid && bank_number == 2'h2 && !graphics_cycle |->
      bank2_select != bank1_select && bank1_select == bank0_select)
      else $error("bank 2 row select wrong");
   a_gfx_cause: assert property (graphics_cycle |->
      $past(cpu_req) && $past(cpu_addr[23:15]) == 9'h017 && idle)
      else $error("graphics cycle without cause");
   a_rom_gated: assert property (rom_chip_select |-> mem_valid)
      else $error("rom select outside an access");
endmodule // mbs_map_asserts
bind mbs_map_top mbs_map_asserts #(.NUM_MAP(NUM_MAP), .NUM_BSW(NUM_BSW),
   .NUM_BSEL(NUM_BSEL)) chk_u (
   .mclk(mclk), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_req(cpu_req), .phys_addr(phys_addr),
   .mem_valid(mem_valid), .bank0_select(bank0_select), .bank1_select(bank1_select),
   .bank2_select(bank2_select), .bank_number(bank_number), .rom_chip_select(rom_chip_select),
   .graphics_cycle(graphics_cycle));
`default_nettype wire

// ---- tb/mbs_map_tb_top.sv ----
// Purpose: Self-checking bench of the bank switch and map block
// Assumes: Register shadows here track every write
// Notes:   Expected translation is rebuilt from the shadows
`timescale 1ns/10ps
`default_nettype none
module mbs_map_tb_top;
   import mbs_pkg::*;
   // ----
   // Signals
   // ----
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, start = 1'b0;
   logic [23:0] addr = 24'h000000, cpu_addr;
   logic cpu_req, mem_valid, bank0_select, bank1_select, bank2_select;
   logic bank_wide, rom_chip_select, graphics_cycle;
   logic [25:0] phys_addr;
   logic [1:0] bank_number, dram_mux;
   mbs_cycle_t cycle_type;
   int failures = 0, checks_done = 0;
   logic [7:0] c0c = 8'h00, c0d = 8'h00;
   logic [11:0] bsw [9] = '{default: 12'h000};
   logic [7:0] bsel [5] = '{default: 8'hc0};
   logic [7:0] mp [34] = '{default: 8'h00};
   logic [11:0] bv [9] = '{12'h9f3, 12'h002, 12'h011, 12'h3c7, 12'h03a, 12'habc, 12'h0f5,
      12'h00d, 12'hfff};
   logic [7:0] sv [5] = '{8'h05, 8'h6e, 8'hb3, 8'hd9, 8'h9a};
   logic [23:0] av [17] = '{24'h0a1234, 24'h0b1234, 24'h0b9234, 24'h0c5678, 24'h0d1234,
      24'h0d5234, 24'h0d9234, 24'h0dd234, 24'h0e4321, 24'h0f8765, 24'h0f8000, 24'h100000,
      24'h1f8000, 24'h200000, 24'h3f0000, 24'h400000, 24'h1d9234};
   always #12.5 mclk = ~mclk;
   mbs_cpu_bfm bfm_u (.mclk(mclk), .rst_b(rst_b), .start(start), .addr(addr),
      .cpu_addr(cpu_addr), .cpu_req(cpu_req));
   mbs_map_top dut_u (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr),
      .cpu_req(cpu_req), .phys_addr(phys_addr), .mem_valid(mem_valid),
      .bank0_select(bank0_select), .bank1_select(bank1_select), .bank2_select(bank2_select),
      .bank_number(bank_number), .cycle_type(cycle_type), .bank_wide(bank_wide),
      .dram_mux(dram_mux), .rom_chip_select(rom_chip_select), .graphics_cycle(graphics_cycle));
   // ----
   // Tasks
   // ----
   task automatic check(input logic [25:0] seen, input logic [25:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      if (a == 8'h0c) c0c = d & 8'h03;
      else if (a == 8'h0d) c0d = d & 8'h03;
      else if (a >= 8'h20 && a <= 8'h28) bsw[a - 8'h20][11:4] = d;
      else if (a >= 8'h80 && a <= 8'h88) bsw[a - 8'h80][3:0] = d[3:0];
      else if (a >= 8'h30 && a <= 8'h34) bsel[a - 8'h30] = d;
      else if (a >= 8'h40 && a <= 8'h61) mp[a - 8'h40] = d;
   endtask
   // Read data stand for one cycle only, so the cycle after must read zero
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 check(26'(reg_rdata), 26'(e));
      @(posedge mclk);
      #1 check(26'(reg_rdata), 26'h0);
   endtask
   function automatic logic [25:0] exp_la(input logic [23:0] a);
      logic [11:0] v;
      case (a[19:16])
         4'hb: v = bsw[a[15]];
         4'hc: v = bsw[2];
         4'hd: v = bsw[3 + a[15:14]];
         4'he: v = bsw[7];
         default: v = bsw[8];
      endcase
      if (!c0c[0] || a[23:20] != 4'h0 || a[19:16] < 4'hb) return {2'h0, a};
      if (a[19:16] == 4'hd) return {v, a[13:0]};
      if (a[19:16] == 4'hb) return {v[11:1], a[14:0]};
      return {v[11:2], a[15:0]};
   endfunction
   function automatic int map_idx(input logic [25:0] la);
      if (!c0d[0]) begin
         if (la < 26'h100000) return int'(la[19:15]);
         if (la < 26'h200000) return 32 + int'(la[19]);
         return -1;
      end
      if (la < 26'h200000) return int'(la[20:16]);
      if (la < 26'h400000) return 32 + int'(la[20]);
      return -1;
   endfunction
   task automatic acc(input logic [23:0] a);
      logic [25:0] la;
      logic [7:0] b;
      logic [5:0] sh;
      logic [2:0] act;
      logic g;
      int ix;
      la = exp_la(a);
      ix = map_idx(la);
      b = (ix < 0) ? bsel[4] : bsel[mp[ix][1:0]];
      sh = (ix < 0) ? 6'h00 : mp[ix][7:2];
      g = c0c[1] && a[23:15] == 9'h017;
      act = (g || b[7:6] == 2'h3) ? 3'h0 : 3'(1 << b[7:6]);
      @(posedge mclk);
      start <= 1'b1;
      addr <= a;
      @(posedge mclk);
      start <= 1'b0;
      @(posedge mclk);
      #1 check(phys_addr, la + ({{20{sh[5]}}, sh} << 17));
      check(26'({bank2_select, bank1_select, bank0_select}), 26'(act ^ {3{~c0d[1]}}));
      check(26'({mem_valid, graphics_cycle, bank_number}), 26'({1'b1, g, b[7:6]}));
      check(26'({rom_chip_select, dram_mux, bank_wide, cycle_type}), 26'(b[5:0]));
      rd(8'h70, (ix < 0) ? 8'h3f : 8'(ix));
   endtask
   // ----
   // Tests
   // ----
   initial begin
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      #1 check(26'({bank2_select, bank1_select, bank0_select, bank_number}), 26'h1f);
      rd(8'h0c, 8'h00);
      rd(8'h30, 8'hc0);
      rd(8'h7f, 8'h00);
      wr(8'h0c, 8'hff);
      rd(8'h0c, 8'h03);
      for (int i = 0; i < 9; i++) begin
         wr(8'h20 + 8'(i), bv[i][11:4]);
         wr(8'h80 + 8'(i), {4'h0, bv[i][3:0]});
      end
      for (int i = 0; i < 5; i++) wr(8'h30 + 8'(i), sv[i]);
      for (int i = 0; i < 34; i++) wr(8'h40 + 8'(i), 8'(i * 37 + 3));
      rd(8'h85, 8'h0c);
      $display("test reset and registers done");
      for (int p = 0; p < 4; p++) begin
         wr(8'h0c, 8'(p));
         wr(8'h0d, 8'(p));
         foreach (av[j]) acc(av[j]);
         $display("test translation pass %0d done", p);
      end
      // A second reset must drop the enable and the row polarity set above
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      #1 check(26'({bank2_select, bank1_select, bank0_select, bank_number}), 26'h1f);
      rd(8'h0c, 8'h00);
      $display("test mid-run reset done");
      report_and_stop;
   end
   initial begin
      repeat (6000) @(posedge mclk);
      failures++;
      report_and_stop;
   end
endmodule // mbs_map_tb_top
`default_nettype wire

// ---- verilog/mbs_map_top.sv ----
// Purpose: Bank switch and memory map front end of a memory controller
// Assumes: Address and register port synchronous to mclk
// Notes:   One cycle from cpu_req to the registered physical address and selects
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "mbs_defines.svh"
`default_nettype none

module mbs_map_top
   import mbs_pkg::*;
#(
   parameter int NUM_MAP = `MBS_NUM_MAP,
   parameter int NUM_BSW = `MBS_NUM_BSW,
   parameter int NUM_BSEL = `MBS_NUM_BSEL
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [23:0] cpu_addr,
   input wire logic cpu_req,
   output logic [25:0] phys_addr,
   output logic mem_valid,
   output logic bank0_select,
   output logic bank1_select,
   output logic bank2_select,
   output logic [1:0] bank_number,
   output mbs_cycle_t cycle_type,
   output logic bank_wide,
   output logic [1:0] dram_mux,
   output logic rom_chip_select,
   output logic graphics_cycle
);

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [7:0] cfg0c_q;
   logic [7:0] cfg0d_q;
   mbs_bsw_t bsw_q [NUM_BSW];
   mbs_byte_t map_q [NUM_MAP];
   mbs_byte_t bsel_q [NUM_BSEL];
   logic [7:0] rdata_q;
   logic [5:0] last_range_q;

   logic bsw_en;
   logic gfx_en;
   logic large_sel;
   logic row_hi;
   assign bsw_en = cfg0c_q[`MBS_CFG0C_BSW_EN];
   assign gfx_en = cfg0c_q[`MBS_CFG0C_GFX_EN];
   assign large_sel = cfg0d_q[`MBS_CFG0D_LARGE];
   assign row_hi = cfg0d_q[`MBS_CFG0D_ROW_HI];

   // ----------------------------------------
   // Configuration writes
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cfg0c_q <= `MBS_RST_CFG;
         cfg0d_q <= `MBS_RST_CFG;
      end else if (reg_wr) begin
         if (reg_addr == `MBS_OFS_CFG0C) begin
            cfg0c_q <= {6'h00, reg_wdata[1:0]};
         end
         if (reg_addr == `MBS_OFS_CFG0D) begin
            cfg0d_q <= {6'h00, reg_wdata[1:0]};
         end
      end
   end

   // Switch registers are twelve bits: upper byte at one offset, low nibble at another
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_BSW; i++) begin
            bsw_q[i] <= `MBS_RST_BSW;
         end
      end else if (reg_wr) begin
         for (int i = 0; i < NUM_BSW; i++) begin
            if (reg_addr == `MBS_OFS_BSW_BASE + 8'(i)) begin
               bsw_q[i][11:4] <= reg_wdata;
            end
            if (reg_addr == `MBS_OFS_BSWLO_BASE + 8'(i)) begin
               bsw_q[i][3:0] <= reg_wdata[3:0];
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_MAP; i++) begin
            map_q[i] <= `MBS_RST_MAP;
         end
      end else if (reg_wr) begin
         for (int i = 0; i < NUM_MAP; i++) begin
            if (reg_addr == `MBS_OFS_MAP_BASE + 8'(i)) begin
               map_q[i] <= reg_wdata;
            end
         end
      end
   end

   // Bank select registers reset to bank 3, an external bank, so no row fires
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_BSEL; i++) begin
            bsel_q[i] <= `MBS_RST_BSEL;
         end
      end else if (reg_wr) begin
         for (int i = 0; i < NUM_BSEL; i++) begin
            if (reg_addr == `MBS_OFS_BSEL_BASE + 8'(i)) begin
               bsel_q[i] <= reg_wdata;
            end
         end
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   logic [7:0] rdata_d;
   always_comb begin
      rdata_d = 8'h00;
      if (reg_addr == `MBS_OFS_CFG0C) rdata_d = cfg0c_q;
      if (reg_addr == `MBS_OFS_CFG0D) rdata_d = cfg0d_q;
      if (reg_addr == `MBS_OFS_STATUS) rdata_d = {2'h0, last_range_q};
      for (int i = 0; i < NUM_BSW; i++) begin
         if (reg_addr == `MBS_OFS_BSW_BASE + 8'(i)) rdata_d = bsw_q[i][11:4];
         if (reg_addr == `MBS_OFS_BSWLO_BASE + 8'(i)) rdata_d = {4'h0, bsw_q[i][3:0]};
      end
      for (int i = 0; i < NUM_MAP; i++) begin
         if (reg_addr == `MBS_OFS_MAP_BASE + 8'(i)) rdata_d = map_q[i];
      end
      for (int i = 0; i < NUM_BSEL; i++) begin
         if (reg_addr == `MBS_OFS_BSEL_BASE + 8'(i)) rdata_d = bsel_q[i];
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_rd ? rdata_d : 8'h00;
      end
   end
   assign reg_rdata = rdata_q;

   // ----------------------------------------
   // Bank switch stage
   // ----------------------------------------
   // Window decode requires bits 23:20 clear; above 1MB is never in the window
   logic in_window;
   logic [3:0] bsw_idx;
   logic [1:0] sub_size;
   logic [25:0] log_addr;
   mbs_bsw_t bsw_sel;

   always_comb begin
      in_window = (cpu_addr[23:20] == 4'h0) && (cpu_addr[19:16] >= 4'hb);
      bsw_idx = 4'h0;
      sub_size = 2'h0;
      case (cpu_addr[19:14])
         6'h2c, 6'h2d: begin
            bsw_idx = 4'h0;
            sub_size = 2'h1;
         end
         6'h2e, 6'h2f: begin
            bsw_idx = 4'h1;
            sub_size = 2'h1;
         end
         6'h30, 6'h31, 6'h32, 6'h33: begin
            bsw_idx = 4'h2;
            sub_size = 2'h2;
         end
         6'h34: bsw_idx = 4'h3;
         6'h35: bsw_idx = 4'h4;
         6'h36: bsw_idx = 4'h5;
         6'h37: bsw_idx = 4'h6;
         6'h38, 6'h39, 6'h3a, 6'h3b: begin
            bsw_idx = 4'h7;
            sub_size = 2'h2;
         end
         6'h3c, 6'h3d, 6'h3e, 6'h3f: begin
            bsw_idx = 4'h8;
            sub_size = 2'h2;
         end
         default: bsw_idx = 4'h0;
      endcase
      bsw_sel = bsw_q[bsw_idx];
      log_addr = {2'h0, cpu_addr};
      if (in_window && bsw_en) begin
         // Full replacement of bits 25:16 lets the result reach all of 64MB
         log_addr[25:16] = bsw_sel[11:2];
         case (sub_size)
            2'h0: log_addr[15:14] = bsw_sel[1:0];
            2'h1: log_addr[15] = bsw_sel[1];
            default: log_addr[15:14] = cpu_addr[15:14];
         endcase
      end
   end

   // ----------------------------------------
   // Mapping stage
   // ----------------------------------------
   logic in_range;
   logic [5:0] range_idx;
   logic [7:0] map_sel;
   logic [2:0] bsel_idx;
   logic [25:0] shift_amt;
   logic [25:0] phys_d;

   always_comb begin
      in_range = 1'b0;
      range_idx = 6'h00;
      if (!large_sel) begin
         if (log_addr[25:20] == 6'h00) begin
            in_range = 1'b1;
            range_idx = {1'b0, log_addr[19:15]};
         end else if (log_addr[25:20] == 6'h01) begin
            in_range = 1'b1;
            range_idx = {5'h10, log_addr[19]};
         end
      end else begin
         if (log_addr[25:21] == 5'h00) begin
            in_range = 1'b1;
            range_idx = {1'b0, log_addr[20:16]};
         end else if (log_addr[25:21] == 5'h01) begin
            in_range = 1'b1;
            range_idx = {5'h10, log_addr[20]};
         end
      end
      map_sel = map_q[range_idx];
      if (in_range) begin
         bsel_idx = {1'b0, map_sel[`MBS_MAP_BSEL_HI:`MBS_MAP_BSEL_LO]};
         // Signed shift; wraps within the 64MB space rather than saturating
         shift_amt = {{3{map_sel[`MBS_MAP_SHIFT_HI]}},
                      map_sel[`MBS_MAP_SHIFT_HI:`MBS_MAP_SHIFT_LO], 17'h00000};
      end else begin
         bsel_idx = 3'h4;
         shift_amt = 26'h0000000;
      end
      phys_d = log_addr + shift_amt;
   end

   // ----------------------------------------
   // Bank outputs
   // ----------------------------------------
   logic [7:0] bsel_val;
   logic gfx_hit;
   logic [2:0] row_act;
   assign bsel_val = bsel_q[bsel_idx];
   assign gfx_hit = gfx_en && (cpu_addr[23:15] == `MBS_GFX_SEG);

   always_comb begin
      row_act = 3'h0;
      if (cpu_req && !gfx_hit) begin
         case (bsel_val[`MBS_BSEL_BANK_HI:`MBS_BSEL_BANK_LO])
            2'h0: row_act = 3'h1;
            2'h1: row_act = 3'h2;
            2'h2: row_act = 3'h4;
            default: row_act = 3'h0;
         endcase
      end
   end

   logic [25:0] phys_q;
   logic valid_q;
   logic [2:0] row_q;
   logic [1:0] bank_q;
   mbs_cycle_t cyc_q;
   logic wide_q;
   logic [1:0] mux_q;
   logic rom_q;
   logic gfx_q;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         phys_q <= 26'h0000000;
         valid_q <= 1'b0;
         gfx_q <= 1'b0;
      end else begin
         phys_q <= phys_d;
         valid_q <= cpu_req;
         gfx_q <= cpu_req && gfx_hit;
      end
   end

   // Polarity applied at the flop so the pins never glitch on a 0D write
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         row_q <= 3'h7;
      end else if (row_hi) begin
         row_q <= row_act;
      end else begin
         row_q <= ~row_act;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         bank_q <= 2'h3;
         cyc_q <= MBS_CYC_DRAM;
         wide_q <= 1'b0;
         mux_q <= 2'h0;
         rom_q <= 1'b0;
      end else begin
         bank_q <= bsel_val[`MBS_BSEL_BANK_HI:`MBS_BSEL_BANK_LO];
         cyc_q <= mbs_cycle_t'(bsel_val[`MBS_BSEL_CYC_HI:`MBS_BSEL_CYC_LO]);
         wide_q <= bsel_val[`MBS_BSEL_WIDE];
         mux_q <= bsel_val[`MBS_BSEL_MUX_HI:`MBS_BSEL_MUX_LO];
         rom_q <= cpu_req && bsel_val[`MBS_BSEL_ROM];
      end
   end

   // Status shows the last range used; 6'h3f marks an out-of-range access
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         last_range_q <= 6'h00;
      end else if (cpu_req) begin
         last_range_q <= in_range ? range_idx : 6'h3f;
      end
   end

   assign phys_addr = phys_q;
   assign mem_valid = valid_q;
   assign bank0_select = row_q[0];
   assign bank1_select = row_q[1];
   assign bank2_select = row_q[2];
   assign bank_number = bank_q;
   assign cycle_type = cyc_q;
   assign bank_wide = wide_q;
   assign dram_mux = mux_q;
   assign rom_chip_select = rom_q;
   assign graphics_cycle = gfx_q;

endmodule // mbs_map_top

`default_nettype wire
